// [inc/phy_event_pkg.sv]
// Package: register map, field layout and carriers for the PHY event unit
package phy_event_pkg;

  // Register address width and data width
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_PHY_STATUS_WORD = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_IRQ_ENABLE = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_IRQ_STATUS = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CONFIG = 5'h14;

  // Event bit positions, shared by enable and status
  localparam int BIT_NEG_ERROR = 15;
  localparam int BIT_RATE_CHANGE = 14;
  localparam int BIT_DUPLEX_CHANGE = 13;
  localparam int BIT_PAGE_RECEIVED = 12;
  localparam int BIT_NEG_DONE = 11;
  localparam int BIT_LINK_CHANGE = 10;
  localparam int BIT_FALSE_CARRIER = 8;
  localparam int BIT_PAIR_SWAP = 6;
  localparam int BIT_DOWNSHIFT = 5;
  localparam int BIT_DOZE_CHANGE = 4;
  localparam int BIT_WAKE_PACKET = 3;
  localparam int BIT_MAC_ERROR = 2;
  localparam int BIT_POLARITY_FLIP = 1;
  localparam int BIT_JABBER = 0;

  // Implemented event bits; bits 9 and 7 are reserved
  localparam logic [DATA_W-1:0] EVENT_VALID_MASK = 16'hFD7F;

  // Status word fields
  localparam int BIT_POLARITY_OK = 1;
  localparam int BIT_JABBER_SEEN = 0;

  // Interrupt configuration field
  localparam int BIT_IRQ_ACTIVE_LOW = 13;

  // Reset values
  localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic POLARITY_OK_RESET = 1'h1;
  localparam logic JABBER_SEEN_RESET = 1'h0;
  localparam logic IRQ_ACTIVE_LOW_RESET = 1'h1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  // One register bus request per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // One-cycle event pulses, laid out as the status register
  typedef struct packed {
    logic negotiation_error;
    logic rate_change;
    logic duplex_change;
    logic page_received;
    logic negotiation_done;
    logic link_change;
    logic unused_9;
    logic false_carrier;
    logic unused_7;
    logic pair_swap_change;
    logic downshift_event;
    logic doze_change;
    logic wake_packet;
    logic mac_side_error;
    logic polarity_flip;
    logic jabber;
  } event_s;

endpackage : phy_event_pkg

// [core/phy_event_interrupt_unit.sv]
// Event latching, interrupt enable and interrupt pin logic of the PHY
//
// Contract
// - Status bit 1 shows polarity, resets to 1
// - Status bit 0 mirrors jabber, not read-cleared
// - Interrupt only for enabled events; enables reset 0
// - Status sets on event whatever the enable
// - Status bit holds until status read
// - Status read returns bits, clears them; reset 0
// - Bit 15 is negotiation error
// - Bit 14 is speed change
// - Bit 13 is duplex change
// - Bit 12 is page received
// - Bit 11 is negotiation complete
// - Bit 10 is link status change
// - Bit 8 false carrier; 9, 7 reserved
// - Bit 6 is crossover change
// - Bit 5 is speed optimization event
// - Bit 4 is sleep mode change
// - Bit 3 is wake packet, read-cleared
// - Bit 2 is MAC-side interface error
// - Bit 1 is polarity change
// - Bit 0 is jabber detected
// - Config bit 13 picks pin level, default low
//
// Implementation choice: the strobed register port.
module phy_event_interrupt_unit
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,

  // Register port
  input wire phy_event_pkg::reg_req_s reg_req,
  output logic [phy_event_pkg::DATA_W-1:0] reg_rdata,

  // Event pulses and live levels from the PHY core
  input wire phy_event_pkg::event_s event_pulse,
  input wire logic polarity_correct,
  input wire logic jabber_detect,

  // Interrupt pin
  output logic irq_pin
);

  // Flattened event vector
  logic [phy_event_pkg::DATA_W-1:0] ev_vec;
  // Latched event status
  logic [phy_event_pkg::DATA_W-1:0] status_q;
  // Next status value
  logic [phy_event_pkg::DATA_W-1:0] status_d;
  // Event enables
  logic [phy_event_pkg::DATA_W-1:0] enable_q;
  // Polarity indication
  logic pol_q;
  // Jabber indication
  logic jab_q;
  // Pin level select
  logic act_low_q;
  // Read data register
  logic [phy_event_pkg::DATA_W-1:0] rdata_q;
  // Pin register
  logic irq_q;
  // Decoded accesses
  logic rd_word;
  logic rd_enable;
  logic rd_status;
  logic rd_config;
  logic wr_enable;
  logic wr_config;
  // An enabled event is pending
  logic pending;
  // Zero word for the properties below; declared here so every use follows it
  localparam logic [phy_event_pkg::DATA_W-1:0] DATA_ZERO_L = phy_event_pkg::DATA_ZERO;

  // Address decode of the strobes
  always_comb
  begin
    rd_word = reg_req.rd && (reg_req.addr == phy_event_pkg::ADDR_PHY_STATUS_WORD);
    rd_enable = reg_req.rd && (reg_req.addr == phy_event_pkg::ADDR_EVENT_IRQ_ENABLE);
    rd_status = reg_req.rd && (reg_req.addr == phy_event_pkg::ADDR_EVENT_IRQ_STATUS);
    rd_config = reg_req.rd && (reg_req.addr == phy_event_pkg::ADDR_IRQ_CONFIG);
    wr_enable = reg_req.wr && (reg_req.addr == phy_event_pkg::ADDR_EVENT_IRQ_ENABLE);
    wr_config = reg_req.wr && (reg_req.addr == phy_event_pkg::ADDR_IRQ_CONFIG);
  end

  // Map event pulses onto status positions
  always_comb
  begin
    // Reserved positions never see an event
    ev_vec = phy_event_pkg::DATA_ZERO;
    ev_vec[phy_event_pkg::BIT_NEG_ERROR] = event_pulse.negotiation_error;
    ev_vec[phy_event_pkg::BIT_RATE_CHANGE] = event_pulse.rate_change;
    ev_vec[phy_event_pkg::BIT_DUPLEX_CHANGE] = event_pulse.duplex_change;
    ev_vec[phy_event_pkg::BIT_PAGE_RECEIVED] = event_pulse.page_received;
    ev_vec[phy_event_pkg::BIT_NEG_DONE] = event_pulse.negotiation_done;
    ev_vec[phy_event_pkg::BIT_LINK_CHANGE] = event_pulse.link_change;
    ev_vec[phy_event_pkg::BIT_FALSE_CARRIER] = event_pulse.false_carrier;
    ev_vec[phy_event_pkg::BIT_PAIR_SWAP] = event_pulse.pair_swap_change;
    ev_vec[phy_event_pkg::BIT_DOWNSHIFT] = event_pulse.downshift_event;
    ev_vec[phy_event_pkg::BIT_DOZE_CHANGE] = event_pulse.doze_change;
    ev_vec[phy_event_pkg::BIT_WAKE_PACKET] = event_pulse.wake_packet;
    ev_vec[phy_event_pkg::BIT_MAC_ERROR] = event_pulse.mac_side_error;
    ev_vec[phy_event_pkg::BIT_POLARITY_FLIP] = event_pulse.polarity_flip;
    ev_vec[phy_event_pkg::BIT_JABBER] = event_pulse.jabber;
  end

  // Next status: a read clears what it returns, a new event still wins
  always_comb
  begin
    status_d = status_q;
    // Clear only bits the read actually returned
    if (rd_status)
    begin
      status_d = phy_event_pkg::DATA_ZERO;
    end
    // Set regardless of enable and of a clear in the same cycle
    status_d = status_d | ev_vec;
  end

  // Latched status register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      status_q <= phy_event_pkg::STATUS_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // Enable register; reserved bits are never stored
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      enable_q <= phy_event_pkg::ENABLE_RESET;
    end
    else if (wr_enable)
    begin
      enable_q <= reg_req.wdata & phy_event_pkg::EVENT_VALID_MASK;
    end
  end

  // Pin level select
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      act_low_q <= phy_event_pkg::IRQ_ACTIVE_LOW_RESET;
    end
    else if (wr_config)
    begin
      act_low_q <= reg_req.wdata[phy_event_pkg::BIT_IRQ_ACTIVE_LOW];
    end
  end

  // Live polarity and jabber copies
  // A read of the status word leaves them alone
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pol_q <= phy_event_pkg::POLARITY_OK_RESET;
      jab_q <= phy_event_pkg::JABBER_SEEN_RESET;
    end
    else
    begin
      pol_q <= polarity_correct;
      jab_q <= jabber_detect;
    end
  end

  // Interrupt request; one cycle of lag keeps the pin glitch free
  assign pending = |(status_q & enable_q);

  // Interrupt pin register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      // Inactive level for the default active-low pin
      irq_q <= phy_event_pkg::IRQ_ACTIVE_LOW_RESET;
    end
    else
    begin
      irq_q <= act_low_q ? !pending : pending;
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata_q <= phy_event_pkg::DATA_ZERO;
    end
    else
    begin
      // Unmapped addresses and idle cycles read as zero
      rdata_q <= phy_event_pkg::DATA_ZERO;
      if (rd_word)
      begin
        // Only the two low bits live here
        rdata_q[phy_event_pkg::BIT_POLARITY_OK] <= pol_q;
        rdata_q[phy_event_pkg::BIT_JABBER_SEEN] <= jab_q;
      end
      else if (rd_enable)
      begin
        rdata_q <= enable_q;
      end
      else if (rd_status)
      begin
        rdata_q <= status_q;
      end
      else if (rd_config)
      begin
        rdata_q[phy_event_pkg::BIT_IRQ_ACTIVE_LOW] <= act_low_q;
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign irq_pin = irq_q;

  // Polarity indication comes out of reset as correct
  property p_pol_reset;
    @(posedge clock)
    $fell(sys_rst) |-> pol_q;
  endproperty
  a_pol_reset: assert property (p_pol_reset)
    else $error("Polarity bit not one after reset");

  // Status word read returns live polarity
  property p_word_read;
    @(posedge clock) disable iff (sys_rst)
    rd_word |=> (rdata_q[phy_event_pkg::BIT_POLARITY_OK] == $past(pol_q));
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("Status word polarity read wrong");

  // Reading the status word returns jabber and does not clear it
  property p_jab_keep;
    @(posedge clock) disable iff (sys_rst)
    (rd_word && jabber_detect)
      |=> jab_q && (rdata_q[phy_event_pkg::BIT_JABBER_SEEN] == $past(jab_q));
  endproperty
  a_jab_keep: assert property (p_jab_keep)
    else $error("Jabber indication cleared by read");

  // Every event lands in status within one cycle
  property p_event_sets;
    @(posedge clock) disable iff (sys_rst)
    (|ev_vec) |=> ((status_q & $past(ev_vec)) == $past(ev_vec));
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("Event did not set its status bit");

  // Pending bits hold while no status read happens
  property p_status_hold;
    @(posedge clock) disable iff (sys_rst)
    !rd_status |=> ((status_q & $past(status_q)) == $past(status_q));
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("Status bit dropped without a read");

  // Quiet status read returns then clears
  property p_status_clear;
    @(posedge clock) disable iff (sys_rst)
    (rd_status && (ev_vec == DATA_ZERO_L))
      |=> (status_q == DATA_ZERO_L) && (rdata_q == $past(status_q));
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("Status read did not return and clear");

  // Enabled pending event drives the pin active
  property p_irq_on;
    @(posedge clock) disable iff (sys_rst)
    pending |=> (irq_pin == !$past(act_low_q));
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("Interrupt pin not active");

  // No enabled pending event keeps the pin idle
  property p_irq_off;
    @(posedge clock) disable iff (sys_rst)
    !pending |=> (irq_pin == $past(act_low_q));
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("Interrupt pin active with nothing pending");

  // Reserved bits never stored
  property p_reserved_zero;
    @(posedge clock) disable iff (sys_rst)
    ((status_q | enable_q) & ~phy_event_pkg::EVENT_VALID_MASK) == DATA_ZERO_L;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bit set");

  // Config write picks the pin level and the idle pin follows the written bit
  property p_cfg_level;
    @(posedge clock) disable iff (sys_rst)
    wr_config ##1 !pending
      |=> (irq_pin == $past(reg_req.wdata[phy_event_pkg::BIT_IRQ_ACTIVE_LOW], 2));
  endproperty
  a_cfg_level: assert property (p_cfg_level)
    else $error("Pin level select not applied");

  // Enable write keeps only implemented bits
  property p_enable_write;
    @(posedge clock) disable iff (sys_rst)
    wr_enable |=> (enable_q == ($past(reg_req.wdata) & phy_event_pkg::EVENT_VALID_MASK));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Enable write not stored as masked");

  // Enable read returns the stored enables
  property p_enable_read;
    @(posedge clock) disable iff (sys_rst)
    rd_enable |=> (rdata_q == $past(enable_q));
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("Enable read wrong");

  // Status read returns what was latched, even with a new event beside it
  property p_status_read;
    @(posedge clock) disable iff (sys_rst)
    rd_status |=> (rdata_q == $past(status_q));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read wrong");

  // Config read returns the pin level select
  property p_config_read;
    @(posedge clock) disable iff (sys_rst)
    rd_config |=> (rdata_q[phy_event_pkg::BIT_IRQ_ACTIVE_LOW] == $past(act_low_q));
  endproperty
  a_config_read: assert property (p_config_read)
    else $error("Config read wrong");

  // Idle cycles, writes and unmapped reads leave read data at zero
  property p_rdata_zero;
    @(posedge clock) disable iff (sys_rst)
    !(rd_word || rd_enable || rd_status || rd_config) |=> (rdata_q == DATA_ZERO_L);
  endproperty
  a_rdata_zero: assert property (p_rdata_zero)
    else $error("Read data not zero outside a read");

  // Inverted polarity shows in the copy; the sampled reset keeps the release edge out
  property p_pol_follow;
    @(posedge clock) disable iff (sys_rst)
    (!sys_rst && !polarity_correct) |=> !pol_q;
  endproperty
  a_pol_follow: assert property (p_pol_follow)
    else $error("Polarity copy not following its input");

  // Jabber copy follows the live flag whatever the reads
  property p_jab_follow;
    @(posedge clock) disable iff (sys_rst)
    (!sys_rst && jabber_detect) |=> jab_q;
  endproperty
  a_jab_follow: assert property (p_jab_follow)
    else $error("Jabber copy not following its input");

  // Reset parks the pin at the inactive level of the default setting
  property p_irq_reset;
    @(posedge clock)
    sys_rst |=> (irq_pin == phy_event_pkg::IRQ_ACTIVE_LOW_RESET);
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("Pin not inactive after reset");

  // Reset clears enables and latched status
  property p_reset_clear;
    @(posedge clock)
    sys_rst |=> (enable_q == phy_event_pkg::ENABLE_RESET)
      && (status_q == phy_event_pkg::STATUS_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Enable or status not cleared by reset");

endmodule : phy_event_interrupt_unit

// [verif/irq_host_model.sv]
// Management host model: turns the interrupt pin into an attention flag
module irq_host_model
(
  // Pin from the device
  input wire logic irq_pin,
  // Level the host believes it configured: 1 means active low
  input wire logic act_low,
  // Attention flag seen by host software
  output logic irq_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // Host decodes with its own copy of the polarity, so a device that
  // ignores the config bit shows up as a wrong attention flag
  assign irq_seen = act_low ? ~irq_pin : irq_pin;
endmodule : irq_host_model

// [verif/phy_event_interrupt_unit_tb_top.sv]
// Self-checking bench for the PHY event and interrupt unit
module phy_event_interrupt_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0; // 20 MHz system clock
  logic sys_rst; // Synchronous reset
  phy_event_pkg::reg_req_s req; // Register request
  logic [15:0] rdata; // Read data
  phy_event_pkg::event_s ev; // Event pulses
  logic polarity_correct; // Live polarity level
  logic jabber_detect; // Live jabber level
  logic irq_pin; // Interrupt pin
  logic act_low; // Host copy of pin polarity
  logic irq_seen; // Host attention flag
  int miscompares = 0;
  int tests_run = 0;

  // Clock generator, half period 25 ns
  always
  begin
    #25 clock = ~clock;
  end

  phy_event_interrupt_unit phy_event_interrupt_unit_i (
    .clock(clock), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata),
    .event_pulse(ev), .polarity_correct(polarity_correct),
    .jabber_detect(jabber_detect), .irq_pin(irq_pin));

  irq_host_model irq_host_model_i (.irq_pin(irq_pin), .act_low(act_low), .irq_seen(irq_seen));

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Single-cycle write strobe
  task automatic reg_write(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    req <= '0;
  endtask : reg_write

  // Single-cycle read strobe; data stands only in the following cycle
  task automatic reg_read(input logic [4:0] addr, output logic [15:0] data);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge clock);
    req <= '0;
    #1 data = rdata;
  endtask : reg_read

  // One-cycle event pulse
  task automatic pulse(input logic [15:0] bits);
    @(posedge clock);
    ev <= bits;
    @(posedge clock);
    ev <= '0;
  endtask : pulse

  // Look at the pin once its registered update has landed
  task automatic check_irq(input logic exp);
    @(posedge clock);
    #1 check("irq_seen", {15'h0000, irq_seen}, {15'h0000, exp});
  endtask : check_irq

  // Verdict and end of run
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // Watchdog so a hang still reaches the verdict
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    logic [15:0] d;
    logic [15:0] m;
    sys_rst = 1'b1;
    req = '0;
    ev = '0;
    polarity_correct = 1'b1;
    jabber_detect = 1'b0;
    act_low = 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    // Reset values
    reg_read(phy_event_pkg::ADDR_PHY_STATUS_WORD, d);
    check("status_word", d, 16'h0002);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_ENABLE, d);
    check("enable", d, 16'h0000);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
    check("event_status", d, 16'h0000);
    check("irq_pin", {15'h0000, irq_pin}, 16'h0001);
    // Each event alone with all enables off: latches, holds, no pin
    for (int b = 0; b < 16; b++)
    begin
      m = 16'hFD7F & (16'h0001 << b);
      pulse(16'h0001 << b);
      repeat (3) @(posedge clock);
      check_irq(1'b0);
      reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
      check("event_status", d, m);
      reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
      check("event_status", d, 16'h0000);
    end
    // Every event in one cycle; reserved bits stay clear
    pulse(16'hFFFF);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
    check("event_status", d, 16'hFD7F);
    // Event in the cycle of a status read survives the clear
    pulse(16'h0020);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: phy_event_pkg::ADDR_EVENT_IRQ_STATUS, wdata: 16'h0000};
    ev <= 16'h0010;
    @(posedge clock);
    req <= '0;
    ev <= '0;
    #1 check("event_status", rdata, 16'h0020);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
    check("event_status", d, 16'h0010);
    // Enable all, reserved enable bits refuse the write
    reg_write(phy_event_pkg::ADDR_EVENT_IRQ_ENABLE, 16'hFFFF);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_ENABLE, d);
    check("enable", d, 16'hFD7F);
    pulse(16'h0400);
    check_irq(1'b1);
    repeat (4) @(posedge clock);
    check("irq_seen", {15'h0000, irq_seen}, 16'h0001);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
    check("event_status", d, 16'h0400);
    check_irq(1'b0);
    // Active-high pin
    reg_write(phy_event_pkg::ADDR_IRQ_CONFIG, 16'h0000);
    act_low <= 1'b0;
    @(posedge clock);
    #1 check("irq_pin", {15'h0000, irq_pin}, 16'h0000);
    pulse(16'h0001);
    check_irq(1'b1);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
    check("event_status", d, 16'h0001);
    reg_write(phy_event_pkg::ADDR_IRQ_CONFIG, 16'hFFFF);
    act_low <= 1'b1;
    reg_read(phy_event_pkg::ADDR_IRQ_CONFIG, d);
    check("irq_config", d, 16'h2000);
    // Live levels, jabber copy survives its own read
    @(posedge clock);
    polarity_correct <= 1'b0;
    jabber_detect <= 1'b1;
    repeat (2) @(posedge clock);
    reg_read(phy_event_pkg::ADDR_PHY_STATUS_WORD, d);
    check("status_word", d, 16'h0001);
    reg_write(phy_event_pkg::ADDR_PHY_STATUS_WORD, 16'hFFFF);
    reg_read(phy_event_pkg::ADDR_PHY_STATUS_WORD, d);
    check("status_word", d, 16'h0001);
    // Writes to the status register and unmapped reads do nothing
    reg_write(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, 16'hFFFF);
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_STATUS, d);
    check("event_status", d, 16'h0000);
    reg_read(5'h1F, d);
    check("unmapped", d, 16'h0000);
    // Mid-run reset restores enables and the default pin level
    reg_write(phy_event_pkg::ADDR_IRQ_CONFIG, 16'h0000);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    reg_read(phy_event_pkg::ADDR_EVENT_IRQ_ENABLE, d);
    check("enable", d, 16'h0000);
    check("irq_pin", {15'h0000, irq_pin}, 16'h0001);
    reg_read(phy_event_pkg::ADDR_IRQ_CONFIG, d);
    check("irq_config", d, 16'h2000);
    complete_run();
  end
endmodule : phy_event_interrupt_unit_tb_top
